// ===== design/spdif_map.vh
// register map, field positions, reset values and timing figures of the serial audio transmitter
`ifndef SPDIF_MAP_VH
`define SPDIF_MAP_VH

`define AXI_ADDR_W 16
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// register indices; byte address is four times the index
`define CTRL_IDX 14'h05c2
`define CS1_IDX 14'h05c3
`define CS2_IDX 14'h05c4
`define CS3_IDX 14'h05c5
`define SRC_A_IDX 14'h0800
`define VOL_A_IDX 14'h0801
`define SRC_B_IDX 14'h0808
`define VOL_B_IDX 14'h0809
`define RATE_IDX 14'h0810
`define PATH_STS_IDX 14'h0811
`define IRQ_STS_IDX 14'h0812
`define IRQ_MASK_IDX 14'h0813

// control fields
`define CTRL_ENA_BIT 0
`define CTRL_VAL_A_BIT 12
`define CTRL_VAL_B_BIT 13
`define CTRL_MASK 16'h3001

// reset values
`define CTRL_RST 16'h0000
`define CS1_RST 16'h0000
`define CS2_RST 16'h0b01
`define CS3_RST 16'h0000
`define CS3_MASK 16'h0fff
`define VOL_RST 8'h80
`define RATE_RST 4'h2

// interrupt status bits
`define IRQ_CLK_ERR_BIT 0
`define IRQ_BLOCK_BIT 1

// preambles, written for a line that idles low
`define PRE_BLOCK 8'he8
`define PRE_A 8'he2
`define PRE_B 8'he4

`define FRAMES_PER_BLOCK 8'd192
`define CS_DEFINED_BITS 40
`define CLK_HZ 200000000
`define HALF_CELLS_PER_FRAME 128
`define MIN_HALF_CELL_CYC 4

`endif

// ===== design/bmc_encoder.v
// biphase-mark serializer for one 32-slot subframe at a time
`timescale 1ns/100ps
`default_nettype none
module bmc_encoder (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // timing and next subframe
    input wire enable,
    input wire half_tick,
    input wire [7:0] preamble,
    input wire [27:0] payload,
    // outputs
    output reg take,
    output reg line
);
    reg [5:0] cell_reg;
    reg [7:0] pre_reg;
    reg [27:0] pay_reg;
    reg base_reg;
    wire [5:0] cell_next;
    wire [4:0] bit_idx;

    assign cell_next = cell_reg + 6'h01;
    assign bit_idx = cell_next[5:1] - 5'h04;

    always @(posedge aclk) begin
        if (!aresetn || !enable) begin
            cell_reg <= 6'h3f;
            pre_reg <= 8'h00;
            pay_reg <= 28'h0000000;
            base_reg <= 1'b0;
            line <= 1'b0;
            take <= 1'b0;
        end else begin
            take <= 1'b0;
            if (half_tick) begin
                if (cell_reg == 6'h3f) begin
                    // preamble is inverted when the line sits high
                    cell_reg <= 6'h00;
                    pre_reg <= preamble;
                    pay_reg <= payload;
                    base_reg <= line;
                    line <= preamble[7] ^ line;
                    take <= 1'b1;
                end else begin
                    cell_reg <= cell_next;
                    if (cell_next < 6'h08) begin
                        line <= pre_reg[3'h7 - cell_next[2:0]] ^ base_reg;
                    end else if (!cell_next[0]) begin
                        line <= ~line;
                    end else if (pay_reg[bit_idx]) begin
                        line <= ~line;
                    end
                end
            end
        end
    end
endmodule // bmc_encoder
`default_nettype wire

// ===== design/spdif_output_generator.v
// serial digital audio transmitter with register slave and clock check
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "spdif_map.vh"

module spdif_output_generator #(
    parameter NUM_SRC = 4,
    parameter CLK_HZ = `CLK_HZ,
    parameter MIN_HALF_CELL_CYC = `MIN_HALF_CELL_CYC
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus, write
    input wire [`AXI_ADDR_W-1:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // register bus, read
    input wire [`AXI_ADDR_W-1:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // audio sources, same clock
    input wire [NUM_SRC*24-1:0] src_sample,
    input wire [NUM_SRC-1:0] src_strobe,
    // outputs
    output wire spdif_out,
    output reg clock_error_out,
    output reg irq
);
    // register state
    reg [15:0] ctrl_reg;
    reg [15:0] cs1_reg;
    reg [15:0] cs2_reg;
    reg [15:0] cs3_reg;
    reg [7:0] sel_a_reg;
    reg [7:0] vol_a_reg;
    reg [7:0] sel_b_reg;
    reg [7:0] vol_b_reg;
    reg [3:0] rate_reg;
    reg [1:0] irq_sts_reg;
    reg [1:0] irq_mask_reg;
    // bus holding
    reg aw_held_reg;
    reg w_held_reg;
    reg [13:0] aw_idx_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    // transmit engine
    reg tx_run_reg;
    reg [31:0] step_reg;
    reg [31:0] acc_reg;
    reg tick_reg;
    reg sub_b_reg;
    reg [7:0] frame_reg;
    wire take;
    wire [47:0] smp_w;
    wire [31:0] acc_sum;
    wire wr_fire;
    wire [31:0] req_hz;
    wire req_ok;
    wire err_evt;
    wire block_evt;
    wire [1:0] irq_set;
    wire [1:0] irq_clr;
    wire [39:0] cs_a;
    wire [39:0] cs_b;
    wire [39:0] cs_cur;
    wire cs_bit;
    wire [23:0] smp_cur;
    wire val_cur;
    wire [26:0] pay_body;
    wire [7:0] pre_cur;
    wire [2:0] path_sts;

    // nominal frame rate per rate code; 0 marks a code with no rate
    function [31:0] rate_hz;
        input [3:0] code;
        begin
            case (code)
                4'h0: rate_hz = 32'd32000;
                4'h1: rate_hz = 32'd44100;
                4'h2: rate_hz = 32'd48000;
                4'h3: rate_hz = 32'd88200;
                4'h4: rate_hz = 32'd96000;
                4'h5: rate_hz = 32'd176400;
                4'h6: rate_hz = 32'd192000;
                default: rate_hz = 32'd0;
            endcase
        end
    endfunction

    function is_mapped;
        input [13:0] idx;
        begin
            case (idx)
                `CTRL_IDX, `CS1_IDX, `CS2_IDX, `CS3_IDX,
                `SRC_A_IDX, `VOL_A_IDX, `SRC_B_IDX, `VOL_B_IDX,
                `RATE_IDX, `PATH_STS_IDX, `IRQ_STS_IDX, `IRQ_MASK_IDX: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
            merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    // volume 80h is unity; result clips to the 24-bit range
    function [23:0] scale;
        input [23:0] smp;
        input [7:0] vol;
        reg signed [32:0] prod;
        reg signed [25:0] shifted;
        begin
            prod = $signed(smp) * $signed({1'b0, vol});
            shifted = prod[32:7];
            if (shifted > 26'sd8388607) begin
                scale = 24'h7fffff;
            end else if (shifted < -26'sd8388608) begin
                scale = 24'h800000;
            end else begin
                scale = shifted[23:0];
            end
        end
    endfunction

    function sel_ok;
        input [7:0] sel;
        begin
            sel_ok = (sel != 8'h00) && ({24'h000000, sel} <= NUM_SRC);
        end
    endfunction

    // per-channel capture; sources are ports only, the line never loops back
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : chan
            reg [23:0] smp_reg;
            wire [7:0] sel;
            wire [7:0] vol;
            integer i;
            reg [23:0] cap;
            reg hit;
            assign sel = (c == 0) ? sel_a_reg : sel_b_reg;
            assign vol = (c == 0) ? vol_a_reg : vol_b_reg;
            always @* begin
                cap = 24'h000000;
                hit = 1'b0;
                for (i = 0; i < NUM_SRC; i = i + 1) begin
                    if (sel == i + 1 && src_strobe[i]) begin
                        cap = src_sample[i*24 +: 24];
                        hit = 1'b1;
                    end
                end
            end
            always @(posedge aclk) begin
                if (!aresetn || !sel_ok(sel)) begin
                    smp_reg <= 24'h000000;
                end else if (hit) begin
                    smp_reg <= scale(cap, vol);
                end
            end
            assign smp_w[c*24 +: 24] = smp_reg;
        end
    endgenerate

    // enable request check against the clock
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
    assign req_hz = rate_hz(rate_reg);
    assign req_ok = (req_hz != 32'd0) &&
        (req_hz * `HALF_CELLS_PER_FRAME * MIN_HALF_CELL_CYC <= CLK_HZ);
    assign err_evt = wr_fire && aw_idx_reg == `CTRL_IDX && w_strb_reg[0] &&
        w_data_reg[`CTRL_ENA_BIT] && !tx_run_reg && !req_ok;
    assign block_evt = take && !sub_b_reg && frame_reg == 8'h00;
    assign irq_set = {block_evt, err_evt};
    assign irq_clr = (wr_fire && aw_idx_reg == `IRQ_STS_IDX && w_strb_reg[0]) ?
        w_data_reg[1:0] : 2'b00;
    assign path_sts = {tx_run_reg && sel_ok(sel_b_reg), tx_run_reg && sel_ok(sel_a_reg),
        tx_run_reg};

    // register bus slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_idx_reg <= 14'h0000;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_idx_reg <= awaddr[15:2];
                aw_held_reg <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                w_held_reg <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid <= 1'b1;
                bresp <= is_mapped(aw_idx_reg) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= is_mapped(araddr[15:2]) ? `RESP_OKAY : `RESP_SLVERR;
                case (araddr[15:2])
                    `CTRL_IDX: rdata <= {16'h0000, ctrl_reg};
                    `CS1_IDX: rdata <= {16'h0000, cs1_reg};
                    `CS2_IDX: rdata <= {16'h0000, cs2_reg};
                    `CS3_IDX: rdata <= {16'h0000, cs3_reg};
                    `SRC_A_IDX: rdata <= {24'h000000, sel_a_reg};
                    `VOL_A_IDX: rdata <= {24'h000000, vol_a_reg};
                    `SRC_B_IDX: rdata <= {24'h000000, sel_b_reg};
                    `VOL_B_IDX: rdata <= {24'h000000, vol_b_reg};
                    `RATE_IDX: rdata <= {28'h0000000, rate_reg};
                    `PATH_STS_IDX: rdata <= {29'h00000000, path_sts};
                    `IRQ_STS_IDX: rdata <= {30'h00000000, irq_sts_reg};
                    `IRQ_MASK_IDX: rdata <= {30'h00000000, irq_mask_reg};
                    default: rdata <= 32'h00000000;
                endcase
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // register file and enable handling
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `CTRL_RST;
            cs1_reg <= `CS1_RST;
            cs2_reg <= `CS2_RST;
            cs3_reg <= `CS3_RST;
            sel_a_reg <= 8'h00;
            vol_a_reg <= `VOL_RST;
            sel_b_reg <= 8'h00;
            vol_b_reg <= `VOL_RST;
            rate_reg <= `RATE_RST;
            irq_mask_reg <= 2'b00;
            tx_run_reg <= 1'b0;
            step_reg <= 32'h00000000;
        end else if (wr_fire) begin
            case (aw_idx_reg)
                `CTRL_IDX: begin
                    ctrl_reg <= merge16(ctrl_reg, w_data_reg, w_strb_reg) & `CTRL_MASK;
                    if (w_strb_reg[0]) begin
                        if (!w_data_reg[`CTRL_ENA_BIT]) begin
                            tx_run_reg <= 1'b0;
                        end else if (!tx_run_reg && req_ok) begin
                            tx_run_reg <= 1'b1;
                            step_reg <= req_hz * `HALF_CELLS_PER_FRAME;
                        end
                    end
                end
                `CS1_IDX: cs1_reg <= merge16(cs1_reg, w_data_reg, w_strb_reg);
                `CS2_IDX: cs2_reg <= merge16(cs2_reg, w_data_reg, w_strb_reg);
                `CS3_IDX: cs3_reg <= merge16(cs3_reg, w_data_reg, w_strb_reg) & `CS3_MASK;
                `SRC_A_IDX: if (w_strb_reg[0]) sel_a_reg <= w_data_reg[7:0];
                `VOL_A_IDX: if (w_strb_reg[0]) vol_a_reg <= w_data_reg[7:0];
                `SRC_B_IDX: if (w_strb_reg[0]) sel_b_reg <= w_data_reg[7:0];
                `VOL_B_IDX: if (w_strb_reg[0]) vol_b_reg <= w_data_reg[7:0];
                `RATE_IDX: if (w_strb_reg[0]) rate_reg <= w_data_reg[3:0];
                `IRQ_MASK_IDX: if (w_strb_reg[0]) irq_mask_reg <= w_data_reg[1:0];
                default: ;
            endcase
        end
    end

    // sticky events; a set in the clearing cycle survives
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_sts_reg <= 2'b00;
            clock_error_out <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
            clock_error_out <= irq_sts_reg[`IRQ_CLK_ERR_BIT];
            irq <= |(irq_sts_reg & irq_mask_reg);
        end
    end

    // half-cell timing from a fractional accumulator; rate is latched at enable
    assign acc_sum = acc_reg + step_reg;
    always @(posedge aclk) begin
        if (!aresetn || !tx_run_reg) begin
            acc_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else if (acc_sum >= CLK_HZ) begin
            acc_reg <= acc_sum - CLK_HZ;
            tick_reg <= 1'b1;
        end else begin
            acc_reg <= acc_sum;
            tick_reg <= 1'b0;
        end
    end

    // frame and subframe position, advanced when the encoder takes a subframe
    always @(posedge aclk) begin
        if (!aresetn || !tx_run_reg) begin
            sub_b_reg <= 1'b0;
            frame_reg <= 8'h00;
        end else if (take) begin
            sub_b_reg <= ~sub_b_reg;
            if (sub_b_reg) begin
                frame_reg <= (frame_reg == `FRAMES_PER_BLOCK - 8'h01) ?
                    8'h00 : frame_reg + 8'h01;
            end
        end
    end

    // channel status, first 40 bits; the rest of the block sends zero
    assign cs_a = {cs3_reg[11:0], cs2_reg[15:12], cs2_reg[7:4],
        cs2_reg[3:0], cs1_reg[15:0]};
    assign cs_b = {cs3_reg[11:0], cs2_reg[15:12], cs2_reg[11:8],
        cs2_reg[3:0], cs1_reg[15:0]};
    assign cs_cur = sub_b_reg ? cs_b : cs_a;
    assign cs_bit = (frame_reg < `CS_DEFINED_BITS) ? cs_cur[frame_reg[5:0]] : 1'b0;
    assign smp_cur = sub_b_reg ? smp_w[47:24] : smp_w[23:0];
    assign val_cur = sub_b_reg ? ctrl_reg[`CTRL_VAL_B_BIT] : ctrl_reg[`CTRL_VAL_A_BIT];
    assign pay_body = {cs_bit, 1'b0, val_cur, smp_cur};
    assign pre_cur = sub_b_reg ? `PRE_B : (frame_reg == 8'h00 ? `PRE_BLOCK : `PRE_A);

    bmc_encoder encoder (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(tx_run_reg),
        .half_tick(tick_reg),
        .preamble(pre_cur),
        .payload({^pay_body, pay_body}),
        .take(take),
        .line(spdif_out)
    );
endmodule // spdif_output_generator
`default_nettype wire

// ===== testbench/spdif_rx_model.sv
// receiver model: measures biphase-mark run lengths on the line
`timescale 1ns/100ps
`default_nettype none
module spdif_rx_model (
    // clock
    input wire logic aclk,
    // line and window
    input wire logic line,
    input wire logic listen,
    // results
    output int bad_run,
    output int nviol,
    output int bad_par,
    output logic [39:0] cs_seen,
    output logic v_a,
    output logic v_b
);
    logic last = 1'b0;
    int run = 1;
    bit armed = 1'b0;
    // half-cells from subframe start, preamble kind, frame in block (-1 unknown)
    int hp = 64;
    int kind = 0;
    int f = -1;
    logic [27:0] word = 28'h0;
    initial bad_run = 0;
    initial nviol = 0;
    initial bad_par = 0;
    initial cs_seen = 40'h0;
    initial v_a = 1'b0;
    initial v_b = 1'b0;
    // half-cell is two cycles, so every run is 2, 4 or 6 cycles long
    always @(posedge aclk) begin
        if (!listen) begin
            armed <= 1'b0;
            run <= 1;
            hp <= 64;
            f <= -1;
        end else if (line !== last) begin
            if (armed && (run < 2 || run > 6 || run[0])) bad_run <= bad_run + 1;
            if (armed && run == 6) nviol <= nviol + 1;
            // a three half-cell run far from the last start opens a subframe
            if (run == 6 && hp > 9) begin
                hp <= 3;
                word <= 28'h0;
                if (kind == 1 || f >= 0) begin
                    if (^word) bad_par <= bad_par + 1;
                    if (kind == 2) v_b <= word[24];
                    else v_a <= word[24];
                end
                if (kind == 1) begin
                    f <= 0;
                    cs_seen[0] <= word[26];
                end else if (kind == 3 && f >= 0) begin
                    f <= f + 1;
                    if (f < 39) cs_seen[f + 1] <= word[26];
                end
            end else begin
                hp <= hp + run / 2;
                if (hp == 3) kind <= run / 2;
                if ((hp + run / 2) % 2 == 1 && hp + run / 2 >= 9 && hp + run / 2 <= 63)
                    word[(hp + run / 2 - 9) / 2] <= 1'b1;
            end
            armed <= 1'b1;
            run <= 1;
        end else begin
            run <= run + 1;
        end
        last <= line;
    end
endmodule // spdif_rx_model
`default_nettype wire

// ===== testbench/spdif_output_generator_properties.sv
// checker for bus handshakes, error pin and reset levels
`timescale 1ns/100ps
`default_nettype none
module spdif_output_generator_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // outputs
    input wire logic spdif_out,
    input wire logic clock_error_out,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_aw_taken_once: assert property (awvalid && awready |=> !awready)
        else $error("awready high after address taken");
    a_w_taken_once: assert property (wvalid && wready |=> !wready)
        else $error("wready high after data taken");
    a_ar_taken_once: assert property (arvalid && arready |=> !arready)
        else $error("arready high after address taken");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write response late");
    a_resp_blocks_write: assert property (bvalid |-> !awready && !wready)
        else $error("write taken during response");
    a_resp_blocks_read: assert property (rvalid |-> !arready)
        else $error("read taken during response");
    a_err_pin_cause: assert property ($rose(clock_error_out) |-> $past(bvalid))
        else $error("error pin rose without a write");
    a_err_pin_clear: assert property ($fell(clock_error_out) |-> $past(bvalid))
        else $error("error pin fell without a write");
    a_reset_quiet: assert property ($rose(aresetn) |-> !spdif_out && !irq && !clock_error_out)
        else $error("outputs active after reset");
endmodule // spdif_output_generator_properties
bind spdif_output_generator spdif_output_generator_properties i_props (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .spdif_out(spdif_out),
    .clock_error_out(clock_error_out), .irq(irq));
`default_nettype wire

// ===== testbench/spdif_output_generator_tb.sv
// self-checking bench for the serial audio transmitter
`timescale 1ns/100ps
`default_nettype none
`include "spdif_map.vh"
module spdif_output_generator_tb;
    // clock chosen so a 192 kHz half-cell is exactly two cycles
    localparam int SYS_HZ = 49152000;
    localparam int BLOCK_CYC = 49152;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0, d, v, seed = 32'hbecc;
    logic [3:0] wstrb = 4'h3, src_strobe = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic listen = 1'b0;
    logic [95:0] src_sample = 96'h0;
    logic [1:0] r;
    wire awready, wready, bvalid, arready, rvalid, spdif_out, clock_error_out, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int bad_count = 0, n_compared = 0, cyc = 0, t0, i, bad_run, nviol, bad_par;
    logic [39:0] cs_seen, e;
    logic v_a, v_b;
    logic [15:0] cs_val [4];
    logic [13:0] ridx [6] = '{`CTRL_IDX, `CS1_IDX, `CS2_IDX, `CS3_IDX, `VOL_A_IDX, `RATE_IDX};
    logic [15:0] rval [6] = '{`CTRL_RST, `CS1_RST, `CS2_RST, `CS3_RST, 16'h0080, 16'h0002};

    spdif_output_generator #(.NUM_SRC(4), .CLK_HZ(SYS_HZ), .MIN_HALF_CELL_CYC(2)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .src_sample(src_sample), .src_strobe(src_strobe), .spdif_out(spdif_out),
        .clock_error_out(clock_error_out), .irq(irq));
    spdif_rx_model i_rx (.aclk(aclk), .line(spdif_out), .listen(listen),
        .bad_run(bad_run), .nviol(nviol), .bad_par(bad_par), .cs_seen(cs_seen),
        .v_a(v_a), .v_b(v_b));

    initial forever #2.5 aclk = ~aclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] kept(input logic [13:0] idx);
        return (idx == `CS3_IDX) ? `CS3_MASK : 16'hffff;
    endfunction

    // sources run on this clock, one sample per 256-cycle frame
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        src_strobe <= {4{cyc[7:0] == 8'h00}};
        if (cyc[7:0] == 8'h00) src_sample <= {rnd(), rnd(), rnd()};
        if (cyc == 90000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [13:0] idx, input logic [15:0] val);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, val};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] idx);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_irq(input int lim);
        i = 0;
        while (irq !== 1'b1 && i < lim) begin
            @(posedge aclk);
            i++;
        end
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            rd(ridx[k]);
            chk(d, {16'h0000, rval[k]});
        end
        repeat (4) begin
            for (int k = 1; k < 4; k++) begin
                v = rnd();
                wr(ridx[k], v[15:0]);
                cs_val[k] = v[15:0] & kept(ridx[k]);
                rd(ridx[k]);
                chk(d, {16'h0000, v[15:0] & kept(ridx[k])});
            end
        end
        rd(14'h0802);
        chk(r, `RESP_SLVERR);
        chk(d, 32'h0);
        rd(`VOL_B_IDX);
        chk(r, `RESP_OKAY);
        $display("test registers done");
        // unknown rate code makes the enable fail
        wr(`IRQ_MASK_IDX, 16'h0003);
        wr(`RATE_IDX, 16'h0007);
        wr(`CTRL_IDX, 16'h0001);
        repeat (2) @(posedge aclk);
        chk(clock_error_out, 1'b1);
        chk(irq, 1'b1);
        rd(`PATH_STS_IDX);
        chk(d[0], 1'b0);
        wr(`IRQ_STS_IDX, 16'h0001);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        wr(`IRQ_MASK_IDX, 16'h0002);
        wr(`CTRL_IDX, 16'h0001);
        repeat (2) @(posedge aclk);
        chk(clock_error_out, 1'b1);
        chk(irq, 1'b0);
        wr(`IRQ_STS_IDX, 16'h0001);
        $display("test clocking error done");
        v = rnd();
        wr(`SRC_A_IDX, 16'h0001);
        wr(`VOL_A_IDX, {8'h00, v[7:0]});
        wr(`SRC_B_IDX, 16'h0002);
        wr(`RATE_IDX, 16'h0006);
        wr(`CTRL_IDX, 16'h3001);
        rd(`PATH_STS_IDX);
        chk(d[2:0], 3'h7);
        wait_irq(3000);
        t0 = cyc;
        chk(irq, 1'b1);
        listen <= 1'b1;
        // a second enable while running must leave the path alone
        wr(`CTRL_IDX, 16'h3001);
        repeat (2) @(posedge aclk);
        chk(clock_error_out, 1'b0);
        rd(`PATH_STS_IDX);
        chk(d[0], 1'b1);
        wr(`IRQ_STS_IDX, 16'h0002);
        repeat (2) @(posedge aclk);
        wait_irq(60000);
        chk(cyc - t0, BLOCK_CYC);
        chk(bad_run, 0);
        chk(nviol > 0, 1'b1);
        // wait until status bits 0..39 of the new block have gone out
        repeat (10500) @(posedge aclk);
        e = {cs_val[3][11:0], cs_val[2][15:12], cs_val[2][7:4], cs_val[2][3:0], cs_val[1]};
        chk(cs_seen[31:0], e[31:0]);
        chk(cs_seen[39:32], e[39:32]);
        chk(bad_par, 0);
        chk(v_a, 1'b1);
        chk(v_b, 1'b1);
        $display("test stream done");
        listen <= 1'b0;
        wr(`CTRL_IDX, 16'h0000);
        repeat (2) @(posedge aclk);
        chk(spdif_out, 1'b0);
        rd(`PATH_STS_IDX);
        chk(d[0], 1'b0);
        $display("test disable done");
        results();
    end
endmodule // spdif_output_generator_tb
`default_nettype wire
